// file: hdl/i2csam_core.sv
// module: i2c slave status flags, masked address match and apb register file
`timescale 1ns/1ps
module i2csam_core
  import i2csam_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // state and bundles

  i2csam_state_type st; // registered state
  i2csam_state_type next_st; // next value of the whole state
  i2csam_apb_req_type req; // bundled apb request
  logic mapped; // address hits a register
  logic acc_write; // write takes effect this edge
  logic acc_read; // read completes this edge

  assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};

  ////////////////////////////////////////////////////////////////////////////////
  // apb handshake

  // zero wait states: every access phase completes at once
  // an unmapped address still gets pready, with pslverr beside it, so a
  // stray access can never stall the bus
  always_comb begin
    mapped = (req.paddr == ADDR_STATUS) || (req.paddr == ADDR_MASK) ||
             (req.paddr == ADDR_RECEIVE) || (req.paddr == ADDR_TRANSMIT) ||
             (req.paddr == ADDR_OWN);
    acc_write = req.psel && req.penable && req.pwrite && mapped;
    acc_read = req.psel && req.penable && !req.pwrite && mapped;
    pready = req.psel && req.penable;
    pslverr = req.psel && req.penable && !mapped; // unmapped address answers error
  end

  // prdata comes from the state flop; the sda pin is open drain and only
  // ever pulls low, so its level is fixed and the enable carries the bit
  assign prdata = st.prdata;
  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign sda_oe = st.sda_drive;

  ////////////////////////////////////////////////////////////////////////////////
  // masked address compare

  // a one in the mask drops that bit from the compare
  // only mask bits 6..0 meet a seven-bit address; bits 9..7 are kept
  // and read back but cannot change a match
  function automatic logic addr_match(input logic [OWN_W-1:0] incoming,
                                      input logic [OWN_W-1:0] own,
                                      input logic [MASK_W-1:0] ignore);
    logic [MASK_W-1:0] diff;
    diff = {{(MASK_W-OWN_W){1'b0}}, incoming ^ own};
    addr_match = ((diff & ~ignore) == '0);
  endfunction : addr_match

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  // one process builds every next value; the engine runs on found scl edges
  // no clock stretching: the engine keeps pace with any scl low time of
  // four or more system clocks
  always_comb begin
    logic scl; // synchronised bus levels
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [BYTE_W-1:0] byte_in; // byte as it stands after this rising edge
    logic rx_set; // hardware load of receive holding
    logic rx_clear; // software read of receive holding
    logic tx_set; // software write of transmit holding
    logic tx_clear; // byte fully sent
    logic [31:0] rd_value; // read mux output
    next_st = st;
    scl = st.scl_sync[1];
    sda = st.sda_sync[1];
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_det = 1'b0;
    stop_det = 1'b0;
    byte_in = {st.shift[BYTE_W-2:0], sda};
    rx_set = 1'b0;
    rx_clear = 1'b0;
    tx_set = 1'b0;
    tx_clear = 1'b0;
    rd_value = '0;

    // two-stage synchronisers; only the second stage feeds logic
    next_st.scl_sync = {st.scl_sync[0], scl_in};
    next_st.sda_sync = {st.sda_sync[0], sda_in};
    next_st.scl_prev = scl;
    next_st.sda_prev = sda;

    // edges compare the second stage with its one-cycle delayed copy, so
    // a first stage caught mid-transition never reaches the engine
    scl_rise = scl && !st.scl_prev;
    scl_fall = !scl && st.scl_prev;
    // sda moving while scl stays high marks a bus condition
    start_det = scl && st.scl_prev && st.sda_prev && !sda;
    stop_det = scl && st.scl_prev && !st.sda_prev && sda;

    if (start_det) begin
      // start and repeated start look the same and restart address capture
      next_st.start_seen = 1'b1;
      next_st.stop_seen = 1'b0;
      next_st.eng = ENG_ADDR;
      next_st.bit_count = '0;
      next_st.sda_drive = 1'b0;
    end else if (stop_det) begin
      next_st.stop_seen = 1'b1;
      next_st.start_seen = 1'b0;
      next_st.eng = ENG_IDLE;
      next_st.sda_drive = 1'b0;
    end else begin
      case (st.eng)
        ENG_IDLE: begin
          // not addressed: ignore bits until the next start
          next_st.sda_drive = 1'b0;
        end
        ENG_ADDR: begin
          if (scl_rise) begin
            next_st.shift = byte_in;
            next_st.bit_count = 4'(st.bit_count + 4'h1);
            if (st.bit_count == LAST_BIT_INDEX) begin
              next_st.addr_hit = addr_match(byte_in[BYTE_W-1:1], st.own_address,
                                            st.address_bit_ignore);
              if (addr_match(byte_in[BYTE_W-1:1], st.own_address, st.address_bit_ignore)) begin
                next_st.data_not_addr = 1'b0;
                next_st.read_not_write = byte_in[0];
              end
            end
          end else if (scl_fall && (st.bit_count == BITS_PER_BYTE)) begin
            // a miss leaves the bus alone; the flags keep the last match
            if (st.addr_hit) begin
              next_st.eng = ENG_ADDR_ACK;
              next_st.sda_drive = 1'b1;
            end else begin
              next_st.eng = ENG_IDLE;
            end
          end
        end
        ENG_ADDR_ACK: begin
          if (scl_fall) begin
            next_st.bit_count = '0;
            if (st.read_not_write) begin
              // first byte comes from the holding register even if it is stale
              next_st.eng = ENG_TX;
              next_st.shift = st.transmit_holding;
              next_st.sda_drive = !st.transmit_holding[BYTE_W-1];
            end else begin
              next_st.eng = ENG_RX;
              next_st.sda_drive = 1'b0;
            end
          end
        end
        ENG_RX: begin
          if (scl_rise) begin
            next_st.shift = byte_in;
            next_st.bit_count = 4'(st.bit_count + 4'h1);
            if (st.bit_count == LAST_BIT_INDEX) begin
              // no overflow guard: a new byte overwrites an unread one
              next_st.receive_holding = byte_in;
              rx_set = 1'b1;
              next_st.data_not_addr = 1'b1;
            end
          end else if (scl_fall && (st.bit_count == BITS_PER_BYTE)) begin
            next_st.eng = ENG_RX_ACK;
            next_st.sda_drive = 1'b1;
          end
        end
        ENG_RX_ACK: begin
          if (scl_fall) begin
            next_st.eng = ENG_RX;
            next_st.bit_count = '0;
            next_st.sda_drive = 1'b0;
          end
        end
        ENG_TX: begin
          if (scl_rise) begin
            next_st.bit_count = 4'(st.bit_count + 4'h1);
          end else if (scl_fall) begin
            if (st.bit_count == BITS_PER_BYTE) begin
              next_st.eng = ENG_TX_ACK;
              next_st.sda_drive = 1'b0; // release for the master ack
            end else begin
              next_st.shift = {st.shift[BYTE_W-2:0], 1'b0};
              next_st.sda_drive = !st.shift[BYTE_W-2];
            end
          end
        end
        ENG_TX_ACK: begin
          if (scl_rise) begin
            // only a transmitted data byte updates the ack result
            next_st.ack_result = sda;
            tx_clear = 1'b1;
          end else if (scl_fall) begin
            next_st.bit_count = '0;
            if (!st.ack_result) begin
              next_st.eng = ENG_TX;
              next_st.shift = st.transmit_holding;
              next_st.sda_drive = !st.transmit_holding[BYTE_W-1];
            end else begin
              next_st.eng = ENG_IDLE; // nack ends the read
            end
          end
        end
        default: begin
          next_st.eng = ENG_IDLE;
          next_st.sda_drive = 1'b0;
        end
      endcase
    end

    // register writes take effect at the access edge
    if (acc_write) begin
      case (req.paddr)
        ADDR_MASK: next_st.address_bit_ignore = req.pwdata[MASK_W-1:0];
        ADDR_TRANSMIT: begin
          next_st.transmit_holding = req.pwdata[BYTE_W-1:0];
          tx_set = 1'b1;
        end
        ADDR_OWN: next_st.own_address = req.pwdata[OWN_W-1:0];
        default: begin
          // status and receive holding are read only
        end
      endcase
    end

    // reads of unused bits and of unmapped addresses return zero
    // read value is captured in the setup cycle so prdata comes from a flop
    case (req.paddr)
      ADDR_STATUS: begin
        rd_value[BIT_ACK_RESULT] = st.ack_result;
        rd_value[BIT_DATA_NOT_ADDR] = st.data_not_addr;
        rd_value[BIT_STOP_SEEN] = st.stop_seen;
        rd_value[BIT_START_SEEN] = st.start_seen;
        rd_value[BIT_READ_NOT_WRITE] = st.read_not_write;
        rd_value[BIT_RX_FULL] = st.receive_holding_full;
        rd_value[BIT_TX_FULL] = st.transmit_holding_full;
      end
      ADDR_MASK: rd_value[MASK_W-1:0] = st.address_bit_ignore;
      ADDR_RECEIVE: rd_value[BYTE_W-1:0] = st.receive_holding;
      ADDR_TRANSMIT: rd_value[BYTE_W-1:0] = st.transmit_holding;
      ADDR_OWN: rd_value[OWN_W-1:0] = st.own_address;
      default: rd_value = '0;
    endcase
    if (req.psel && !req.penable && !req.pwrite) begin
      next_st.prdata = rd_value;
    end

    // software read of the receive holding clears its full flag
    // the clear waits for the access edge, so a setup that is never
    // completed leaves an unread byte marked full
    rx_clear = acc_read && (req.paddr == ADDR_RECEIVE);

    // a set in the same cycle as a clear wins: the hardware set for receive, the software write for transmit
    next_st.receive_holding_full = rx_set || (st.receive_holding_full && !rx_clear);
    next_st.transmit_holding_full = tx_set || (st.transmit_holding_full && !tx_clear);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  // constants only under reset; bus lines idle high
  // the synchroniser and its delayed copy start at the idle level, so
  // leaving reset never looks like a start or a stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.eng <= ENG_IDLE;
      st.scl_sync <= SYNC_IDLE;
      st.sda_sync <= SYNC_IDLE;
      st.scl_prev <= 1'b1;
      st.sda_prev <= 1'b1;
      st.address_bit_ignore <= MASK_RESET;
      st.own_address <= OWN_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule : i2csam_core

// file: common/i2csam_pkg.sv
// package: register map, status layout, engine states and state record of the i2c status block
package i2csam_pkg;

  // register byte addresses on the apb side
  localparam logic [7:0] ADDR_STATUS = 8'h00; // serial_bus_status_reg, read only
  localparam logic [7:0] ADDR_MASK = 8'h04; // slave_address_mask_reg
  localparam logic [7:0] ADDR_RECEIVE = 8'h08; // receive_holding_reg, read clears full flag
  localparam logic [7:0] ADDR_TRANSMIT = 8'h0C; // transmit_holding_reg
  localparam logic [7:0] ADDR_OWN = 8'h10; // own 7-bit slave address

  // status bit positions
  localparam int BIT_ACK_RESULT = 15;
  localparam int BIT_DATA_NOT_ADDR = 5;
  localparam int BIT_STOP_SEEN = 4;
  localparam int BIT_START_SEEN = 3;
  localparam int BIT_READ_NOT_WRITE = 2;
  localparam int BIT_RX_FULL = 1;
  localparam int BIT_TX_FULL = 0;

  // widths and counts
  localparam int MASK_W = 10; // address_bit_ignore field, bits 9..0
  localparam int OWN_W = 7; // seven-bit addressing
  localparam int BYTE_W = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT_INDEX = 4'h7;

  // reset values
  localparam logic [MASK_W-1:0] MASK_RESET = 10'h000;
  localparam logic [OWN_W-1:0] OWN_RESET = 7'h00;
  localparam logic [1:0] SYNC_IDLE = 2'h3; // both synchroniser stages at the idle bus level

  // byte engine states
  typedef enum logic [2:0] {
    ENG_IDLE = 3'b000, // not addressed, waiting for a start
    ENG_ADDR = 3'b001, // shifting in the address byte
    ENG_ADDR_ACK = 3'b010, // driving ack for a matched address
    ENG_RX = 3'b011, // shifting in a data byte
    ENG_RX_ACK = 3'b100, // driving ack for a received data byte
    ENG_TX = 3'b101, // shifting out a data byte
    ENG_TX_ACK = 3'b110 // sampling the master ack or nack
  } i2csam_eng_type;

  // apb request bundle
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } i2csam_apb_req_type;

  // whole state of the block
  typedef struct packed {
    i2csam_eng_type eng;
    logic [1:0] scl_sync; // bit 0 first stage, bit 1 second stage
    logic [1:0] sda_sync;
    logic scl_prev; // delayed second stage for edge finding
    logic sda_prev;
    logic [3:0] bit_count;
    logic [BYTE_W-1:0] shift;
    logic addr_hit;
    logic sda_drive;
    logic ack_result;
    logic data_not_addr;
    logic stop_seen;
    logic start_seen;
    logic read_not_write;
    logic receive_holding_full;
    logic transmit_holding_full;
    logic [BYTE_W-1:0] receive_holding;
    logic [BYTE_W-1:0] transmit_holding;
    logic [MASK_W-1:0] address_bit_ignore;
    logic [OWN_W-1:0] own_address;
    logic [31:0] prdata;
  } i2csam_state_type;

endpackage : i2csam_pkg

// file: verif/i2csam_checker.sv
// checker: apb answer and sda pin relations of the i2c status block
`timescale 1ns/1ps
module i2csam_checker
  import i2csam_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  ////////////////////////////////////////
  // address decode seen from the bus side
  wire logic mapped = paddr inside {ADDR_STATUS, ADDR_MASK, ADDR_RECEIVE, ADDR_TRANSMIT, ADDR_OWN};
  wire logic rd = psel && penable && !pwrite; // read access phase
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // zero wait states: answer in the first access cycle
  property p_ready; pready == (psel && penable); endproperty
  a_ready: assert property (p_ready) else $error("pready not tied to access phase");
  property p_err; pslverr |-> pready && !mapped; endproperty
  a_err: assert property (p_err) else $error("error on a mapped address");
  property p_ok; psel && penable && mapped |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_err_data; rd && pslverr |-> prdata == 32'h00000000; endproperty
  a_err_data: assert property (p_err_data) else $error("refused read returned data");
  property p_mask_hi; rd && paddr == ADDR_MASK |-> prdata[31:10] == 22'h000000; endproperty
  a_mask_hi: assert property (p_mask_hi) else $error("mask upper bits not zero");
  property p_stat_hi; rd && paddr == ADDR_STATUS |-> prdata[14:6] == 9'h000; endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("unused status bits set");
  // open drain: the pin level itself is never driven high
  property p_sda_out; sda_out == 1'b0; endproperty
  a_sda_out: assert property (p_sda_out) else $error("sda driven high");
  // the slave moves sda only while scl is low, otherwise it fakes a start or stop
  property p_oe_edge; $changed(sda_oe) |-> !scl_in; endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("sda moved while scl high");
endmodule : i2csam_checker

bind i2csam_core i2csam_checker u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe));

// file: verif/i2csam_bus_master.sv
// partner: behavioural i2c bus master, open drain data, clock still between frames
`timescale 1ns/1ps
module i2csam_bus_master (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // bus idle: both lines released high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // pin changes land between system clock edges, never on one
  task automatic align;
    #((35 - $time % 20) % 20);
  endtask : align
  // one bit: data set in scl low, sampled late in scl high for settle margin
  task automatic bit_io(input logic b, output logic s);
    align;
    sda_drv = b;
    #40 scl = 1'b1;
    #80 s = sda;
    scl = 1'b0;
    #40;
  endtask : bit_io
  // start or repeated start: sda falls while scl high
  task automatic start;
    align;
    sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
    #40;
  endtask : start
  // stop: sda rises while scl high, then the clock stands
  task automatic stop;
    align;
    sda_drv = 1'b0;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #80;
  endtask : stop
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
    output logic ack_seen);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_seen);
  endtask : xfer
endmodule : i2csam_bus_master

// file: verif/tb_top.sv
// testbench: apb register checks and i2c slave transfers against the status block
`timescale 1ns/1ps
module tb_top;
  import i2csam_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, r, v;
  logic pready, pslverr, sda_out, sda_oe, scl, sda_drv, ak, err;
  logic [6:0] own;
  logic [7:0] d, rx;
  wire logic sda_w = sda_drv & ~sda_oe; // pull-up wire, either side pulls low
  int miscompares = 0, check_count = 0, cyc = 0;
  always #10 pclk = ~pclk;
  i2csam_core u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  i2csam_bus_master u_mst (.scl(scl), .sda_drv(sda_drv), .sda(sda_w));
  ////////////////////////////////////////
  task automatic final_report;
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      $display("BAD %s exp %h got %h", nm, e, s);
      miscompares++;
    end
  endtask : chk
  // one apb transfer; waits for pready however long the slave takes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // f packs {ack, data, stop, start, read, rx full, tx full}
  function automatic logic [31:0] st(input logic [6:0] f);
    return {16'h0000, f[6], 9'h000, f[5:0]};
  endfunction : st
  task automatic status(input logic [6:0] f);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", st(f), r);
  endtask : status
  ////////////////////////////////////////
  // hang guard: cycle ceiling well above the whole sequence
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      final_report;
    end
  end
  initial begin
    void'($urandom(32'h9935));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    status(7'h00);
    apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
    apb(1'b1, ADDR_RECEIVE, 32'hFFFFFFFF);
    status(7'h00);
    v = $urandom;
    apb(1'b1, ADDR_MASK, v);
    apb(1'b0, ADDR_MASK, 32'h0);
    chk("mask", v & 32'h000003FF, r);
    own = 7'($urandom);
    apb(1'b1, ADDR_OWN, {25'h0, own});
    apb(1'b0, ADDR_OWN, 32'h0);
    chk("own", {25'h0, own}, r);
    apb(1'b1, ADDR_MASK, 32'h0);
    // master write: address, one data byte, software read, stop
    u_mst.start;
    status(7'h08);
    u_mst.xfer({own, 1'b0}, 1'b1, rx, ak);
    chk("addr ack", 32'h0, {31'h0, ak});
    status(7'h08);
    d = 8'($urandom);
    u_mst.xfer(d, 1'b1, rx, ak);
    status(7'h2A);
    apb(1'b0, ADDR_RECEIVE, 32'h0);
    chk("receive", {24'h0, d}, r);
    status(7'h28);
    u_mst.stop;
    status(7'h30);
    // each masked bit may differ, the next unmasked one may not
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, ADDR_MASK, 32'h1 << k);
      u_mst.start;
      u_mst.xfer({own ^ 7'(1 << k), 1'b0}, 1'b1, rx, ak);
      u_mst.stop;
      chk("masked hit", 32'h0, {31'h0, ak});
      u_mst.start;
      u_mst.xfer({own ^ 7'(1 << ((k + 1) % 7)), 1'b0}, 1'b1, rx, ak);
      u_mst.stop;
      chk("unmasked miss", 32'h1, {31'h0, ak});
    end
    apb(1'b1, ADDR_MASK, 32'h0);
    // master read: ack the first byte, nack the second
    d = 8'($urandom);
    apb(1'b1, ADDR_TRANSMIT, {24'h0, d});
    apb(1'b0, ADDR_TRANSMIT, 32'h0);
    chk("transmit", {24'h0, d}, r);
    status(7'h11);
    u_mst.start;
    status(7'h09);
    u_mst.xfer({own, 1'b1}, 1'b1, rx, ak);
    status(7'h0D);
    u_mst.xfer(8'hFF, 1'b0, rx, ak);
    chk("tx byte", {24'h0, d}, {24'h0, rx});
    status(7'h0C);
    u_mst.xfer(8'hFF, 1'b1, rx, ak);
    status(7'h4C);
    u_mst.stop;
    status(7'h54);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, r);
    final_report;
  end
endmodule : tb_top
